/* File: ocrc_defs.svh */
`ifndef OCRC_DEFS_SVH
`define OCRC_DEFS_SVH

// Response configuration field positions
`define OCRC_RESP_MSB      7
`define OCRC_RESP_LSB      6
`define OCRC_RETRY_MSB     5
`define OCRC_RETRY_LSB     3
`define OCRC_DELAY_MSB     2
`define OCRC_DELAY_LSB     0

// Response codes
`define OCRC_RESP_IGNORE   2'h0
`define OCRC_RESP_COND_CC  2'h1
`define OCRC_RESP_DELAY    2'h2
`define OCRC_RESP_DISABLE  2'h3

// Retry codes
`define OCRC_RETRY_NONE    3'h0
`define OCRC_RETRY_MAXCNT  3'h4
`define OCRC_RETRY_FOREVER 3'h7

// Configuration reset value
`define OCRC_CFG_RESET     8'h00

// Delay unit tick counter and unit count widths
`define OCRC_UNIT_W        16
`define OCRC_DLY_W         8

`endif

/* File: ocrc_pkg.sv */
package ocrc_pkg;

  typedef enum logic [2:0] {
    OCRC_RUN,
    OCRC_LIMIT,
    OCRC_WAIT,
    OCRC_RESTART,
    OCRC_LATCHED
  } ocrc_state_t;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } ocrc_cfg_t;

  typedef struct packed {
    logic oc_fault;
    logic cur_limit;
    logic low_volt;
  } ocrc_sense_t;

endpackage : ocrc_pkg

/* File: ocrc_ctrl.sv */
`timescale 1ns/1ps
`include "ocrc_defs.svh"

// Overview of operation
// - Code 10: limit current for programmed delay
// - Still limiting after delay: apply retry setting
// - Code 11: shut down at once, then retry
// - Retry count taken from bits five to three
// - Retry zero: stay off until cleared
// - Codes 1-4 retry; failures latch off
// - All-ones retry code: retry without limit
// - Restart starts spaced by delay times unit
// - Delay field decodes to power-of-two units
// - Every code sets status bit, notifies host
// - Code 00: brickwall limit, never shut down
// - Code 01: shut down below low-voltage threshold
module ocrc_ctrl (
  // Clock, reset, enable
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     clk_en_i,
  // Configuration write port
  input  wire logic                     cfg_wr_i,
  input  wire logic [7:0]               cfg_wdata_i,
  input  wire logic [`OCRC_UNIT_W-1:0]  unit_cycles_i,
  input  wire logic                     notify_supported_i,
  // Converter sense pins
  input  wire logic                     oc_fault_i,
  input  wire logic                     cur_limit_i,
  input  wire logic                     low_volt_i,
  // Host commands
  input  wire logic                     fault_clear_i,
  input  wire logic                     cmd_off_i,
  // Outputs
  output logic [7:0]                    cfg_rdata_o,
  output logic                          output_en_o,
  output logic                          limit_en_o,
  output logic                          restart_o,
  output logic                          latched_off_o,
  output logic                          oc_status_o,
  output logic                          notify_o
);

  ocrc_pkg::ocrc_sense_t sync1_ff, sync2_ff;
  ocrc_pkg::ocrc_sense_t sense;
  ocrc_pkg::ocrc_cfg_t   cfg_ff, nxt_cfg;
  ocrc_pkg::ocrc_state_t state_ff, nxt_state;
  logic [2:0]                   left_ff, nxt_left;
  logic [`OCRC_DLY_W-1:0]       units_ff, nxt_units;
  logic [`OCRC_UNIT_W-1:0]      tick_ff, nxt_tick;
  logic                         out_en_ff, nxt_out_en;
  logic                         lim_ff, nxt_lim;
  logic                         rst_pulse_ff, nxt_rst_pulse;
  logic                         status_ff, nxt_status;
  logic                         notify_ff, nxt_notify;
  logic                         latched_ff, nxt_latched;
  logic                         oc_prev_ff;
  logic                         unit_done, delay_done, oc_rise;

  function automatic logic [`OCRC_DLY_W-1:0] dly_units(input logic [2:0] code);
    dly_units = `OCRC_DLY_W'(1) << code;
  endfunction : dly_units

  // Shut down then either wait for a restart or latch off
  function automatic ocrc_pkg::ocrc_state_t after_shutdown(input logic [2:0] left,
                                                            input logic [2:0] code);
    if (code == `OCRC_RETRY_NONE || left == 3'h0) begin
      after_shutdown = ocrc_pkg::OCRC_LATCHED;
    end else begin
      after_shutdown = ocrc_pkg::OCRC_WAIT;
    end
  endfunction : after_shutdown

  function automatic logic [2:0] retry_load(input logic [2:0] code);
    retry_load = (code > `OCRC_RETRY_MAXCNT && code != `OCRC_RETRY_FOREVER)
                 ? `OCRC_RETRY_MAXCNT : code;
  endfunction : retry_load

  assign sense      = sync2_ff;
  assign unit_done  = (tick_ff >= unit_cycles_i);
  assign delay_done = unit_done && (units_ff <= `OCRC_DLY_W'(1));
  assign oc_rise    = sense.oc_fault && !oc_prev_ff;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      oc_prev_ff <= 1'b0;
    end else if (clk_en_i) begin
      sync1_ff   <= {oc_fault_i, cur_limit_i, low_volt_i};
      sync2_ff   <= sync1_ff;
      oc_prev_ff <= sync2_ff.oc_fault;
    end
  end

  always_comb begin
    nxt_cfg       = cfg_ff;
    nxt_state     = state_ff;
    nxt_left      = left_ff;
    nxt_units     = units_ff;
    nxt_tick      = unit_done ? '0 : tick_ff + `OCRC_UNIT_W'(1);
    nxt_out_en    = out_en_ff;
    nxt_lim       = lim_ff;
    nxt_rst_pulse = 1'b0;
    nxt_status    = status_ff;
    nxt_notify    = 1'b0;
    if (cfg_wr_i) begin
      nxt_cfg = ocrc_pkg::ocrc_cfg_t'(cfg_wdata_i);
    end
    if (oc_rise) begin
      nxt_notify = notify_supported_i;
    end
    if (fault_clear_i) begin
      nxt_status = 1'b0;
    end
    if (sense.oc_fault) begin
      nxt_status = 1'b1;
    end
    if (fault_clear_i || cmd_off_i) begin
      nxt_left = retry_load(cfg_ff.retry);
    end
    case (state_ff)
      ocrc_pkg::OCRC_RUN: begin
        nxt_out_en = !cmd_off_i;
        nxt_lim    = 1'b0;
        if (sense.oc_fault && !cmd_off_i) begin
          case (cfg_ff.resp)
            `OCRC_RESP_IGNORE, `OCRC_RESP_COND_CC: begin
              nxt_lim   = 1'b1;
              nxt_state = ocrc_pkg::OCRC_LIMIT;
            end
            `OCRC_RESP_DELAY: begin
              nxt_lim   = 1'b1;
              nxt_units = dly_units(cfg_ff.delay);
              nxt_tick  = '0;
              nxt_state = ocrc_pkg::OCRC_LIMIT;
            end
            default: begin
              nxt_out_en = 1'b0;
              nxt_units  = dly_units(cfg_ff.delay);
              nxt_tick   = '0;
              nxt_state  = after_shutdown(left_ff, cfg_ff.retry);
            end
          endcase
        end
      end
      ocrc_pkg::OCRC_LIMIT: begin
        if (cmd_off_i) begin
          nxt_lim   = 1'b0;
          nxt_state = ocrc_pkg::OCRC_RUN;
        end else if (!sense.oc_fault && !sense.cur_limit) begin
          nxt_lim   = 1'b0;
          nxt_state = ocrc_pkg::OCRC_RUN;
        end else if (cfg_ff.resp == `OCRC_RESP_COND_CC && sense.low_volt) begin
          nxt_lim    = 1'b0;
          nxt_out_en = 1'b0;
          nxt_units  = dly_units(cfg_ff.delay);
          nxt_tick   = '0;
          nxt_state  = after_shutdown(left_ff, cfg_ff.retry);
        end else if (cfg_ff.resp == `OCRC_RESP_DELAY) begin
          if (unit_done) begin
            nxt_units = units_ff - `OCRC_DLY_W'(1);
          end
          if (delay_done && sense.cur_limit) begin
            nxt_lim    = 1'b0;
            nxt_out_en = 1'b0;
            nxt_units  = dly_units(cfg_ff.delay);
            nxt_tick   = '0;
            nxt_state  = after_shutdown(left_ff, cfg_ff.retry);
          end else if (delay_done) begin
            nxt_lim   = 1'b0;
            nxt_state = ocrc_pkg::OCRC_RUN;
          end
        end
      end
      ocrc_pkg::OCRC_WAIT: begin
        if (unit_done) begin
          nxt_units = units_ff - `OCRC_DLY_W'(1);
        end
        if (cmd_off_i) begin
          nxt_state = ocrc_pkg::OCRC_RUN;
        end else if (delay_done) begin
          nxt_out_en    = 1'b1;
          nxt_rst_pulse = 1'b1;
          if (cfg_ff.retry != `OCRC_RETRY_FOREVER) begin
            nxt_left = left_ff - 3'h1;
          end
          nxt_units = dly_units(cfg_ff.delay);
          nxt_tick  = '0;
          nxt_state = ocrc_pkg::OCRC_RESTART;
        end
      end
      ocrc_pkg::OCRC_RESTART: begin
        // Attempt is judged over one delay window after its start
        if (unit_done) begin
          nxt_units = units_ff - `OCRC_DLY_W'(1);
        end
        if (cmd_off_i) begin
          nxt_state = ocrc_pkg::OCRC_RUN;
        end else if (sense.oc_fault) begin
          nxt_out_en = 1'b0;
          nxt_state  = after_shutdown(left_ff, cfg_ff.retry);
        end else if (delay_done) begin
          nxt_left  = retry_load(cfg_ff.retry);
          nxt_state = ocrc_pkg::OCRC_RUN;
        end
      end
      ocrc_pkg::OCRC_LATCHED: begin
        nxt_out_en = 1'b0;
        if (fault_clear_i || cmd_off_i) begin
          nxt_state = ocrc_pkg::OCRC_RUN;
        end
      end
      default: begin
        nxt_state = ocrc_pkg::OCRC_RUN;
      end
    endcase
    // Latch-off flag follows the state register so the output comes from a flop
    nxt_latched = (nxt_state == ocrc_pkg::OCRC_LATCHED);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg_ff       <= ocrc_pkg::ocrc_cfg_t'(`OCRC_CFG_RESET);
      state_ff     <= ocrc_pkg::OCRC_RUN;
      left_ff      <= 3'h0;
      units_ff     <= '0;
      tick_ff      <= '0;
      out_en_ff    <= 1'b0;
      lim_ff       <= 1'b0;
      rst_pulse_ff <= 1'b0;
      status_ff    <= 1'b0;
      notify_ff    <= 1'b0;
      latched_ff   <= 1'b0;
    end else if (clk_en_i) begin
      cfg_ff       <= nxt_cfg;
      state_ff     <= nxt_state;
      left_ff      <= nxt_left;
      units_ff     <= nxt_units;
      tick_ff      <= nxt_tick;
      out_en_ff    <= nxt_out_en;
      lim_ff       <= nxt_lim;
      rst_pulse_ff <= nxt_rst_pulse;
      status_ff    <= nxt_status;
      notify_ff    <= nxt_notify;
      latched_ff   <= nxt_latched;
    end
  end

  assign cfg_rdata_o   = cfg_ff;
  assign output_en_o   = out_en_ff;
  assign limit_en_o    = lim_ff;
  assign restart_o     = rst_pulse_ff;
  assign latched_off_o = latched_ff;
  assign oc_status_o   = status_ff;
  assign notify_o      = notify_ff;

endmodule : ocrc_ctrl

/* File: ocrc_host.sv */
`timescale 1ns/1ps
module ocrc_host (
  // Clock
  input  wire logic mclk_i,
  // Host writes
  output logic       cfg_wr_o,
  output logic [7:0] cfg_wdata_o,
  output logic       fault_clear_o
);
  initial begin
    cfg_wr_o = 1'b0;
    cfg_wdata_o = 8'h00;
    fault_clear_o = 1'b0;
  end
  task automatic write_cfg(input logic [7:0] v);
    @(posedge mclk_i) #1;
    cfg_wr_o = 1'b1;
    cfg_wdata_o = v;
    @(posedge mclk_i) #1;
    cfg_wr_o = 1'b0;
    cfg_wdata_o = ~v; // Released data lines must not keep the last byte
    fault_clear_o = 1'b1;
    @(posedge mclk_i) #1;
    fault_clear_o = 1'b0;
  endtask : write_cfg
endmodule : ocrc_host

/* File: ocrc_ctrl_chk.sv */
`timescale 1ns/1ps
module ocrc_ctrl_chk (
  // Inputs watched
  input wire logic       mclk_i, rst_n_i, clk_en_i, cfg_wr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic       notify_supported_i, oc_fault_i, cmd_off_i,
  // Outputs watched
  input wire logic [7:0] cfg_rdata_o,
  input wire logic       output_en_o, limit_en_o, restart_o,
  input wire logic       latched_off_o, oc_status_o, notify_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_CFG_WR: assert property (cfg_wr_i && clk_en_i |=> cfg_rdata_o == $past(cfg_wdata_i))
    else $error("config readback differs");
  AST_NO_RETRY: assert property (restart_o |-> cfg_rdata_o[5:3] != 3'h0)
    else $error("restart with retry zero");
  AST_RESTART_PULSE: assert property (restart_o && clk_en_i |=> !restart_o)
    else $error("restart pulse too long");
  AST_LATCH_OFF: assert property (latched_off_o |-> !output_en_o && !restart_o)
    else $error("output on while latched off");
  AST_FOREVER: assert property ($rose(latched_off_o) |-> cfg_rdata_o[5:3] != 3'h7)
    else $error("latched off with endless retry");
  AST_NO_LIMIT: assert property ($rose(limit_en_o) |-> cfg_rdata_o[7:6] != 2'h3)
    else $error("limiting with disable code");
  AST_IGNORE_ON: assert property ($fell(output_en_o) && !$past(cmd_off_i)
    |-> cfg_rdata_o[7:6] != 2'h0)
    else $error("shutdown with ignore code");
  AST_NOTIFY: assert property (notify_o && clk_en_i |-> notify_supported_i ##1 !notify_o)
    else $error("bad notify pulse");
  AST_STATUS: assert property ($rose(oc_status_o) |-> $past(oc_fault_i, 3))
    else $error("status set without fault");
endmodule : ocrc_ctrl_chk
bind ocrc_ctrl ocrc_ctrl_chk u_chk (.mclk_i, .rst_n_i, .clk_en_i, .cfg_wr_i, .cfg_wdata_i,
  .notify_supported_i, .oc_fault_i, .cmd_off_i, .cfg_rdata_o, .output_en_o, .limit_en_o,
  .restart_o, .latched_off_o, .oc_status_o, .notify_o);

/* File: ocrc_ctrl_test.sv */
`timescale 1ns/1ps
module ocrc_ctrl_test;
  typedef struct packed {
    logic [7:0] cfg;
    logic       lv, cl;
    logic [7:0] rs;
    logic       lat, lim;
  } ocrc_row_t;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_off = 1'b0;
  logic clk_en = 1'b1;
  logic notify_sup = 1'b1;
  logic notify;
  ocrc_pkg::ocrc_sense_t sense = '0;
  logic cfg_wr, fault_clear, output_en, limit_en, restart, latched_off, oc_status;
  logic [7:0] cfg_wdata, cfg_rdata;
  int num_errors = 0;
  int checks_done = 0;
  int cnt;
  int ncnt;
  int ds [4] = '{0, 1, 3, 7};
  ocrc_row_t rows [9] = '{'{8'hc0,0,0,0,1,0}, '{8'hc8,0,0,1,1,0}, '{8'he0,0,0,4,1,0},
    '{8'hf8,0,0,8'hff,0,0}, '{8'h92,0,1,2,1,0}, '{8'h08,0,1,0,0,1},
    '{8'h48,0,1,0,0,1}, '{8'h48,1,1,1,1,0}, '{8'hf0,0,0,4,1,0}};
  always #2.5 mclk_i = ~mclk_i;
  ocrc_host host (.mclk_i(mclk_i), .cfg_wr_o(cfg_wr), .cfg_wdata_o(cfg_wdata),
    .fault_clear_o(fault_clear));
  ocrc_ctrl dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en), .cfg_wr_i(cfg_wr),
    .cfg_wdata_i(cfg_wdata), .unit_cycles_i(16'h0003), .notify_supported_i(notify_sup),
    .oc_fault_i(sense.oc_fault), .cur_limit_i(sense.cur_limit), .low_volt_i(sense.low_volt),
    .fault_clear_i(fault_clear), .cmd_off_i(cmd_off), .cfg_rdata_o(cfg_rdata),
    .output_en_o(output_en), .limit_en_o(limit_en), .restart_o(restart),
    .latched_off_o(latched_off), .oc_status_o(oc_status), .notify_o(notify));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task automatic cmp_rng(input string n, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, g);
    end
  endtask : cmp_rng
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  // Back to a clean run state, then program and clear
  task automatic prep(input logic [7:0] c);
    sense = '0;
    cmd_off = 1'b1;
    tick(6);
    cmd_off = 1'b0;
    host.write_cfg(c);
    tick(1);
  endtask : prep
  task automatic run_row(input ocrc_row_t r);
    prep(r.cfg);
    sense = {1'b1, r.cl, r.lv};
    cnt = 0;
    ncnt = 0;
    repeat (300) begin
      tick(1);
      if (restart === 1'b1) cnt++;
      if (notify === 1'b1) ncnt++;
    end
    cmp("notify", 8'h01, 8'(ncnt));
    cmp_rng("restarts", (r.rs == 8'hff) ? 5 : r.rs, (r.rs == 8'hff) ? 999 : r.rs, cnt);
    cmp("latched", {7'h0, r.lat}, {7'h0, latched_off});
    cmp("limit", {7'h0, r.lim}, {7'h0, limit_en});
    cmp("status", 8'h01, {7'h0, oc_status});
  endtask : run_row
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    tick(20);
    rst_n_i = 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    foreach (ds[i]) begin
      prep(8'hc8 + 8'(ds[i]));
      sense = 3'b100;
      for (cnt = 0; output_en !== 1'b0 && cnt < 50; cnt++) tick(1);
      for (cnt = 1; restart !== 1'b1 && cnt < 700; cnt++) tick(1);
      cmp_rng("spacing", (4 << ds[i]) - 3, (4 << ds[i]) + 3, cnt);
      $display("spacing %0d done", ds[i]);
    end
    notify_sup = 1'b0;
    prep(8'hc0);
    sense = 3'b100;
    ncnt = 0;
    repeat (20) begin
      tick(1);
      if (notify === 1'b1) ncnt++;
    end
    cmp("notify off", 8'h00, 8'(ncnt));
    notify_sup = 1'b1;
    sense = '0;
    tick(8);
    cmp("held off", 8'h01, {7'h0, latched_off});
    // Frozen clock enable: neither the write nor the clear may land
    clk_en = 1'b0;
    host.write_cfg(8'h00);
    tick(2);
    cmp("frozen cfg", 8'hc0, cfg_rdata);
    cmp("frozen latch", 8'h01, {7'h0, latched_off});
    clk_en = 1'b1;
    host.write_cfg(8'hc0);
    tick(2);
    cmp("cleared", 8'h03, {6'h0, output_en, ~latched_off});
    cmp("status clr", 8'h00, {7'h0, oc_status});
    rst_n_i = 1'b0;
    tick(20);
    cmp("reset", 8'h00, cfg_rdata | {output_en, limit_en, latched_off, 5'h0});
    rst_n_i = 1'b1;
    $display("clear and reset done");
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge mclk_i);
    num_errors++;
    $display("[FAIL] watchdog exp done got timeout");
    print_verdict();
  end
endmodule : ocrc_ctrl_test
